// *** bst_tap.sv ***
// boundary scan test access port with system-clock pin control
`timescale 1ns/1ns
`include "bst_regs.svh"
module bst_tap
  import bst_pkg::*;
#(
  // identification fields, values arbitrary
  parameter logic [`BST_ID_REV_W-1:0]  ID_REV  = 3'h1,
  parameter logic [`BST_ID_PART_W-1:0] ID_PART = 17'h00A5A,
  parameter logic [`BST_ID_VEND_W-1:0] ID_VEND = 11'h2B3
) (
  // system clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     ce,
  // test port pins
  input  wire logic                     tck,
  input  wire logic                     tms,
  input  wire logic                     tdi,
  output logic                          tdo,
  output logic                          tdo_oe,
  // pin ring seen by the boundary cells
  input  wire logic [`BST_PIN_CNT-1:0]  ring_in,
  // pin control toward the memory pads
  output bst_pin_ctl_t                  pin_ctl,
  output logic                          q_bus_oe
);

  // --------------------------------------------------------------------------
  // test clock reset
  // --------------------------------------------------------------------------
  // power-up reset reaches the test clock through the pin synchroniser; the
  // test clock must run a few edges while rst_n is low
  logic                     trst_n;
  logic [`BST_PIN_CNT-1:0]  ring_s;
  logic                     ack_s;
  logic                     req_s;
  // link and system state, declared ahead of the synchronisers that read them
  bst_link_st_t lk;
  bst_link_st_t next_lk;
  bst_sys_st_t  sys;
  bst_sys_st_t  next_sys;

  bst_sync #(.W(1)) u_rst_sync (
    .clk   (tck),
    .rst_n (1'b1),
    .ce    (1'b1),
    .d     (rst_n),
    .q     (trst_n)
  );

  bst_sync #(.W(`BST_PIN_CNT)) u_ring_sync (
    .clk   (tck),
    .rst_n (trst_n),
    .ce    (1'b1),
    .d     (ring_in),
    .q     (ring_s)
  );

  bst_sync #(.W(1)) u_ack_sync (
    .clk   (tck),
    .rst_n (trst_n),
    .ce    (1'b1),
    .d     (sys.ack),
    .q     (ack_s)
  );

  bst_sync #(.W(1)) u_req_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .d     (lk.req),
    .q     (req_s)
  );

  // --------------------------------------------------------------------------
  // link state on the test clock
  // --------------------------------------------------------------------------
  bst_pin_ctl_t live;
  logic         bsr_op;
  logic         ser_bit;
  logic [`BST_ID_W-1:0] id_word;

  assign id_word = {ID_REV, ID_PART, ID_VEND, `BST_ID_START};

  always_comb begin
    next_lk = lk;
    bsr_op  = (lk.ir == `BST_OP_EXTEST) || (lk.ir == `BST_OP_SAMPLE_Z)
              || (lk.ir == `BST_OP_PRELOAD);

    // controller, tms high five times from anywhere lands in reset
    unique case (lk.tap)
      ST_TLR:    next_lk.tap = tms ? ST_TLR    : ST_RTI;
      ST_RTI:    next_lk.tap = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: next_lk.tap = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: next_lk.tap = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  next_lk.tap = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: next_lk.tap = tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: next_lk.tap = tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: next_lk.tap = tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: next_lk.tap = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: next_lk.tap = tms ? ST_TLR    : ST_CAP_IR;
      ST_CAP_IR: next_lk.tap = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  next_lk.tap = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: next_lk.tap = tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: next_lk.tap = tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: next_lk.tap = tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: next_lk.tap = tms ? ST_SEL_DR : ST_RTI;
    endcase

    unique case (lk.tap)
      ST_TLR: begin
        // test logic only; memory pins return to normal use
        next_lk.ir                = `BST_OP_IDCODE;
        next_lk.pre[`BST_TRI_CELL] = 1'b0;
      end
      ST_CAP_IR: begin
        next_lk.ir_sh = `BST_IR_CAPTURE;
      end
      ST_SH_IR: begin
        next_lk.ir_sh = {tdi, lk.ir_sh[`BST_IR_W-1:1]};
      end
      ST_UPD_IR: begin
        next_lk.ir = lk.ir_sh;
      end
      ST_CAP_DR: begin
        if (lk.ir == `BST_OP_IDCODE) begin
          next_lk.idr = id_word;
        end else if (bsr_op) begin
          // cell 109 is internal and captures its own latched value
          next_lk.bsr = {lk.pre[`BST_TRI_CELL], ring_s};
        end else begin
          // bypass and the reserved codes all see the bypass bit
          next_lk.byp = 1'b0;
        end
      end
      ST_SH_DR: begin
        if (lk.ir == `BST_OP_IDCODE) begin
          next_lk.idr = {tdi, lk.idr[`BST_ID_W-1:1]};
        end else if (bsr_op) begin
          next_lk.bsr = {tdi, lk.bsr[`BST_BSR_LEN-1:1]};
        end else begin
          next_lk.byp = tdi;
        end
      end
      ST_UPD_DR: begin
        // capture-out and preload-in share one shift pass
        if ((lk.ir == `BST_OP_EXTEST) || (lk.ir == `BST_OP_PRELOAD)) begin
          next_lk.pre = lk.bsr;
        end
      end
      default: begin
      end
    endcase

    // serial bit presented at the LSB of the selected register
    if (lk.tap == ST_SH_IR) begin
      ser_bit = lk.ir_sh[0];
    end else if (lk.ir == `BST_OP_IDCODE) begin
      ser_bit = lk.idr[0];
    end else if (bsr_op) begin
      ser_bit = lk.bsr[0];
    end else begin
      ser_bit = lk.byp;
    end

    // pad control implied by the active instruction and latched cells
    live.extest     = (lk.ir == `BST_OP_EXTEST);
    live.float_q    = (lk.ir == `BST_OP_SAMPLE_Z);
    live.q_drive_en = lk.pre[`BST_TRI_CELL];
    live.drive      = lk.pre[`BST_PIN_CNT-1:0];

    // word crossing: new word only once the last one was acknowledged;
    // a change made just before the test clock stops waits for more edges
    if ((lk.req == ack_s) && (lk.held != live)) begin
      next_lk.held = live;
      next_lk.req  = ~lk.req;
    end
  end

  always_ff @(posedge tck) begin
    if (!trst_n) begin
      lk     <= '0;
      lk.tap <= ST_TLR;
      lk.ir  <= `BST_OP_IDCODE;
    end else begin
      lk <= next_lk;
    end
  end

  // --------------------------------------------------------------------------
  // serial output on the falling test clock edge
  // --------------------------------------------------------------------------
  always_ff @(negedge tck) begin
    if (!trst_n) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo    <= ser_bit;
      tdo_oe <= (lk.tap == ST_SH_IR) || (lk.tap == ST_SH_DR);
    end
  end

  // --------------------------------------------------------------------------
  // system clock side
  // --------------------------------------------------------------------------
  always_comb begin
    next_sys = sys;
    if (req_s != sys.ack) begin
      // held word stays stable while the request is outstanding
      next_sys.out = lk.held;
      next_sys.ack = ~sys.ack;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sys <= '0;
    end else if (ce) begin
      sys <= next_sys;
    end
  end

  // q bus: normal, floated by sample-with-float, or cell 109 under extest
  logic q_oe_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_oe_r <= 1'b1;
    end else if (ce) begin
      if (next_sys.out.extest) begin
        q_oe_r <= next_sys.out.q_drive_en;
      end else begin
        q_oe_r <= ~next_sys.out.float_q;
      end
    end
  end

  assign pin_ctl  = sys.out;
  assign q_bus_oe = q_oe_r;
endmodule

// *** bst_regs.svh ***
// constants of the boundary scan test port
`ifndef BST_REGS_SVH
`define BST_REGS_SVH

// ----------------------------------------------------------------------------
// instruction register
// ----------------------------------------------------------------------------
`define BST_IR_W          3
`define BST_OP_EXTEST     3'h0
`define BST_OP_IDCODE     3'h1
`define BST_OP_SAMPLE_Z   3'h2
`define BST_OP_PRELOAD    3'h4
`define BST_OP_BYPASS     3'h7
`define BST_IR_CAPTURE    3'h1

// ----------------------------------------------------------------------------
// data registers
// ----------------------------------------------------------------------------
`define BST_BSR_LEN       109
`define BST_PIN_CNT       108
`define BST_TRI_CELL      108
`define BST_ID_W          32
`define BST_ID_REV_W      3
`define BST_ID_PART_W     17
`define BST_ID_VEND_W     11
`define BST_ID_START      1'h1

`endif

// *** bst_pkg.sv ***
// types shared by the boundary scan test port
package bst_pkg;
  `include "bst_regs.svh"

  typedef enum logic [3:0] {
    ST_TLR, ST_RTI,
    ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } bst_tap_state_t;

  // control handed from the test clock to the system clock
  typedef struct packed {
    logic                     extest;
    logic                     float_q;
    logic                     q_drive_en;
    logic [`BST_PIN_CNT-1:0]  drive;
  } bst_pin_ctl_t;

  typedef struct packed {
    bst_tap_state_t           tap;
    logic [`BST_IR_W-1:0]     ir_sh;
    logic [`BST_IR_W-1:0]     ir;
    logic                     byp;
    logic [`BST_ID_W-1:0]     idr;
    logic [`BST_BSR_LEN-1:0]  bsr;
    logic [`BST_BSR_LEN-1:0]  pre;
    bst_pin_ctl_t             held;
    logic                     req;
  } bst_link_st_t;

  typedef struct packed {
    logic                     ack;
    bst_pin_ctl_t             out;
  } bst_sys_st_t;
endpackage

// *** bst_sync.sv ***
// three-stage synchroniser with agreement filter
`timescale 1ns/1ns
module bst_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          ce,
  // data
  input  wire logic [W-1:0]  d,
  output logic      [W-1:0]  q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } bst_sync_st_t;

  bst_sync_st_t st;
  bst_sync_st_t next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = d;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // a bit counts only once stages two and three agree
    for (int i = 0; i < W; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.q[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign q = st.q;
endmodule

// *** bst_tap_assertions.sv ***
// checker for the boundary scan test port
`timescale 1ns/1ns
`include "bst_regs.svh"
module bst_tap_assertions
  import bst_pkg::*;
#(
  parameter logic [`BST_ID_VEND_W-1:0] ID_VEND = 11'h001
) (
  // system side
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire logic                    ce,
  input wire bst_pin_ctl_t            pin_ctl,
  input wire logic                    q_bus_oe,
  // test port
  input wire logic                    tck,
  input wire logic                    tms,
  input wire logic                    tdi,
  input wire logic                    tdo,
  input wire logic                    tdo_oe,
  input wire logic [`BST_PIN_CNT-1:0] ring_in
);
  // ----
  // walks from reset into shift-IR and shift-DR
  // ----
  sequence s_ir;
    tms [*5] ##1 !tms ##1 tms [*2] ##1 !tms [*2];
  endsequence
  sequence s_dr;
    tms [*5] ##1 !tms ##1 tms ##1 !tms [*2];
  endsequence
  AST_TLR_QUIET: assert property (
    @(posedge tck) disable iff (!rst_n) tms [*5] |=> !tdo_oe)
    else $error("serial output driven after mode select reset");
  AST_OE_ENTRY: assert property (
    @(posedge tck) disable iff (!rst_n) $rose(tdo_oe) |-> !$past(tms))
    else $error("serial output enabled without entering shift");
  AST_OE_LEAVE: assert property (
    @(posedge tck) disable iff (!rst_n) tdo_oe && tms |=> !tdo_oe)
    else $error("serial output still driven after leaving shift");
  AST_OE_STAY: assert property (
    @(posedge tck) disable iff (!rst_n) tdo_oe && !tms |=> tdo_oe)
    else $error("serial output dropped while shifting");
  AST_IR_LOW: assert property (
    @(posedge tck) disable iff (!rst_n) s_ir |=> tdo_oe && tdo)
    else $error("instruction capture low bit not one");
  AST_IR_MID: assert property (
    @(posedge tck) disable iff (!rst_n) s_ir ##1 !tms |=> !tdo)
    else $error("instruction capture second bit not zero");
  AST_ID_START: assert property (
    @(posedge tck) disable iff (!rst_n) s_dr |=> tdo_oe && tdo)
    else $error("identification start bit not one");
  AST_ID_VEND: assert property (
    @(posedge tck) disable iff (!rst_n) s_dr ##1 !tms |=> tdo == ID_VEND[0])
    else $error("identification vendor low bit wrong");
  AST_Q_OE: assert property (
    @(posedge clk) disable iff (!rst_n)
    q_bus_oe == (pin_ctl.extest ? pin_ctl.q_drive_en : !pin_ctl.float_q))
    else $error("output bus enable disagrees with pin control");
  COV_IR: cover property (@(posedge tck) disable iff (!rst_n) s_ir);
  COV_DR: cover property (@(posedge tck) disable iff (!rst_n) s_dr);
  COV_EXT: cover property (@(posedge clk) disable iff (!rst_n) $rose(pin_ctl.extest));
  COV_FLT: cover property (@(posedge clk) disable iff (!rst_n) $fell(q_bus_oe));
endmodule

bind bst_tap bst_tap_assertions #(
  .ID_VEND (ID_VEND)
) bst_tap_assertions_inst (
  .clk      (clk),
  .rst_n    (rst_n),
  .ce       (ce),
  .pin_ctl  (pin_ctl),
  .q_bus_oe (q_bus_oe),
  .tck      (tck),
  .tms      (tms),
  .tdi      (tdi),
  .tdo      (tdo),
  .tdo_oe   (tdo_oe),
  .ring_in  (ring_in)
);

// *** bst_jtag_model.sv ***
// board-side controller model driving the test port
`timescale 1ns/1ns
module bst_jtag_model (
  // test port pins
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  // ----
  // clock parks low between frames; pulled-up lines rest high
  // ----
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h1;
  end
  // one 15 ns period; tdo taken just before the rise
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #7;
    o = tdo;
    tck = 1'h1;
    #8;
    tck = 1'h0;
  endtask
  task automatic walk(input int n, input logic m);
    logic o;
    repeat (n) step(m, 1'h1, o);
  endtask
  // idle to shift, n bits lsb first, then update and idle; never reserved codes
  task automatic scan(input logic ir, input logic [108:0] din, input int n,
                      output logic [108:0] dout);
    logic o;
    dout = '0;
    walk(ir ? 2 : 1, 1'h1);
    walk(2, 1'h0);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    walk(1, 1'h1);
    walk(1, 1'h0);
  endtask
endmodule

// *** bst_tap_tb.sv ***
// self-checking bench for the boundary scan test port
`timescale 1ns/1ns
`include "bst_regs.svh"
module bst_tap_tb;
  import bst_pkg::*;
  localparam logic [107:0] RING = {9{12'hA5C}};
  localparam logic [107:0] PRE  = {9{12'h3E1}};
  // identification fields, values arbitrary
  localparam logic [31:0]  ID   = {3'h5, 17'h1C3A6, 11'h4D1, 1'h1};
  typedef struct {
    logic [2:0]   ir;
    logic [108:0] din;
    int           n;
    logic [108:0] dout;
    logic [2:0]   pins;
  } bst_row_t;
  logic         clk;
  logic         rst_n;
  logic         ce;
  logic         tck;
  logic         tms;
  logic         tdi;
  logic         tdo;
  logic         tdo_oe;
  logic [107:0] ring_in;
  bst_pin_ctl_t pin_ctl;
  logic         q_bus_oe;
  bst_row_t     rows [5];
  logic [108:0] got;
  int           n_fail = 0;
  int           n_tests = 0;
  int           cyc = 0;

  bst_tap #(
    .ID_REV  (3'h5),
    .ID_PART (17'h1C3A6),
    .ID_VEND (11'h4D1)
  ) bst_tap_inst (
    .clk      (clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .tck      (tck),
    .tms      (tms),
    .tdi      (tdi),
    .tdo      (tdo),
    .tdo_oe   (tdo_oe),
    .ring_in  (ring_in),
    .pin_ctl  (pin_ctl),
    .q_bus_oe (q_bus_oe)
  );
  bst_jtag_model bst_jtag_model_inst (
    .tck (tck),
    .tms (tms),
    .tdi (tdi),
    .tdo (tdo)
  );

  // ----
  // clock, watchdog and reporting
  // ----
  initial clk = 1'h0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic check(input logic [108:0] seen, input logic [108:0] want);
    n_tests++;
    if (seen !== want) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    rst_n   = 1'h0;
    ce      = 1'h1;
    ring_in = RING;
    rows[0] = '{3'h1, 109'h0, 32, {77'h0, ID}, 3'h1};
    rows[1] = '{3'h7, 109'hA, 4, 109'h4, 3'h1};
    rows[2] = '{3'h4, {1'h1, PRE}, 109, {1'h0, RING}, 3'h1};
    rows[3] = '{3'h2, 109'h0, 109, {1'h1, RING}, 3'h2};
    rows[4] = '{3'h0, {1'h0, ~PRE}, 109, {1'h1, RING}, 3'h4};
    // test clock must run while reset passes its synchroniser
    fork
      bst_jtag_model_inst.walk(12, 1'h1);
      begin
        repeat (8) @(negedge clk);
        rst_n = 1'h1;
      end
    join
    check(tdo_oe, 1'h0);
    check({pin_ctl.q_drive_en, pin_ctl.extest, q_bus_oe}, 3'h1);
    bst_jtag_model_inst.walk(1, 1'h0);
    foreach (rows[i]) begin
      bst_jtag_model_inst.scan(1'h1, {106'h0, rows[i].ir}, 3, got);
      check(got, 109'h1);
      bst_jtag_model_inst.scan(1'h0, rows[i].din, rows[i].n, got);
      check(got, rows[i].dout);
      bst_jtag_model_inst.walk(12, 1'h0);
      check({pin_ctl.extest, pin_ctl.float_q, q_bus_oe}, rows[i].pins);
    end
    // high tri-state cell under external test lets the bus drive
    @(negedge clk);
    ring_in = ~RING;
    bst_jtag_model_inst.walk(4, 1'h0);
    bst_jtag_model_inst.scan(1'h0, {1'h1, PRE}, 109, got);
    check(got, {1'h0, ~RING});
    bst_jtag_model_inst.walk(12, 1'h0);
    check({pin_ctl.q_drive_en, q_bus_oe}, 2'h3);
    check(pin_ctl.drive, PRE);
    // mode select reset in mid-shift drops external test
    bst_jtag_model_inst.walk(1, 1'h1);
    bst_jtag_model_inst.walk(5, 1'h0);
    bst_jtag_model_inst.walk(17, 1'h1);
    check({pin_ctl.extest, pin_ctl.q_drive_en, q_bus_oe}, 3'h1);
    bst_jtag_model_inst.walk(1, 1'h0);
    bst_jtag_model_inst.scan(1'h0, 109'h0, 32, got);
    check(got, {77'h0, ID});
    give_verdict();
  end
endmodule
